// File: pkg/adc_ctrl_pkg.sv
// constants and types shared by the converter control block
package adc_ctrl_pkg;
  localparam int SYS_CLK_KHZ = 200000;
  localparam int INT_FAST_KHZ = 1500;
  localparam int INT_SLOW_KHZ = 225;
  localparam int FAST_DIV = SYS_CLK_KHZ / INT_FAST_KHZ;
  localparam int SLOW_DIV = SYS_CLK_KHZ / INT_SLOW_KHZ;
  localparam int TICK_W = 10;
  localparam int RES_BITS = 12;
  localparam logic [3:0] CTRL_BITS = 4'h8;
  localparam logic [3:0] RES_MSB = 4'hb;
  localparam logic [1:0] MODE_EXT = 2'h3;
  localparam logic [1:0] MODE_INT = 2'h2;
  localparam logic [1:0] MODE_UNASSIGNED = 2'h1;
  localparam logic [1:0] MODE_PD = 2'h0;
  localparam int CHAN_HI = 6;
  localparam int CHAN_LO = 4;
  localparam int UNI_POS = 3;
  localparam int SGL_POS = 2;
  localparam logic [7:0] CTRL_START = 8'h01;
  localparam logic [11:0] CODE_ZERO = 12'h000;
  localparam logic [11:0] CODE_ONE = 12'h001;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SHIFT = 4'b0010,
    ST_CONV_EXT = 4'b0100,
    ST_CONV_INT = 4'b1000
  } conv_state_t;
endpackage : adc_ctrl_pkg

// File: pkg/pin_evt_if.sv
// synchronised pin levels and serial clock edge events
`timescale 1ns/100ps
interface pin_evt_if;
  logic sclk_rise;
  logic sclk_fall;
  logic cs_n;
  logic din;
  logic hard_shutdown_pin_n;
  logic hard_shutdown_pin_open;
  logic comp;
  modport src (output sclk_rise, sclk_fall, cs_n, din, hard_shutdown_pin_n, hard_shutdown_pin_open, comp);
  modport dst (input sclk_rise, sclk_fall, cs_n, din, hard_shutdown_pin_n, hard_shutdown_pin_open, comp);
endinterface : pin_evt_if

// File: rtl/pin_sync.sv
// two-stage pin synchronisers and serial clock edge finder
`timescale 1ns/100ps
module pin_sync
  import adc_ctrl_pkg::*;
(
  input wire logic clock_i,      // system clock
  input wire logic sys_rst_i,    // synchronous reset
  input wire logic sclk_i,       // serial clock pin
  input wire logic cs_n_i,       // chip select pin
  input wire logic din_i,        // serial data pin
  input wire logic hard_shutdown_pin_n_i,     // shutdown pin level
  input wire logic hard_shutdown_pin_open_i,  // shutdown pin floating
  input wire logic comp_i,       // comparator decision
  pin_evt_if.src ev              // events to the core
);
  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic prev;
    logic rise;
    logic fall;
  } sync_t;

  sync_t q;
  sync_t d;

  always_comb begin
    d = q;
    d.s1 = {sclk_i, cs_n_i, din_i, hard_shutdown_pin_n_i, hard_shutdown_pin_open_i, comp_i};
    d.s2 = q.s1;
    d.prev = q.s2[5];
    // edges only from the second stage
    d.rise = q.s2[5] & ~q.prev;
    d.fall = ~q.s2[5] & q.prev;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q <= '{s1: 6'h14, s2: 6'h14, prev: 1'b0, rise: 1'b0, fall: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign ev.sclk_rise = q.rise;
  assign ev.sclk_fall = q.fall;
  assign ev.cs_n = q.s2[4];
  assign ev.din = q.s2[3];
  assign ev.hard_shutdown_pin_n = q.s2[2];
  assign ev.hard_shutdown_pin_open = q.s2[1];
  assign ev.comp = q.s2[0];
endmodule : pin_sync

// File: rtl/adc_power_clock_mode_ctrl.sv
// serial control, clock mode and power-down sequencing of the converter
// Functional notes
// - mode bits: 11 external clock, 10 internal clock, 00 power-down, 01 unassigned
// - shutdown high: 225kHz internal clock; open: 1.5MHz; low: power-down
// - software power-down waits until the running conversion completes
// - internal mode: result still shifts out during software power-down
// - first one on data input is the start bit and wakes the device
// - high mode bit keeps power; both clear powers down after one conversion
// - shutdown low aborts any conversion at once, hardware power-down
// - code step is span over 4096; bipolar result in two's complement
// - code transitions sit midway between integer step values
// - strobe falling edge marks conversion running, result bits coming
// - mode bits are last two; conversion starts on fall after eighth bit
// - shutdown low overrides the mode bits
// - external mode: strobe high one period, then 12 falling-edge decisions
// - internal mode: strobe low during conversion, high once result stored
`timescale 1ns/100ps
module adc_power_clock_mode_ctrl
  import adc_ctrl_pkg::*;
#(
  parameter int FAST_DIV_P = FAST_DIV,
  parameter int SLOW_DIV_P = SLOW_DIV
) (
  input wire logic clock_i,                  // 200 MHz system clock
  input wire logic sys_rst_i,                // synchronous reset, high
  input wire logic sclk_i,                   // serial clock pin
  input wire logic cs_n_i,                   // chip select pin, low active
  input wire logic din_i,                    // serial data in pin
  input wire logic hard_shutdown_pin_i,      // shutdown pin, low = off
  input wire logic shutdown_pin_open_i,      // shutdown pin left floating
  input wire logic comp_i,                   // comparator: input above trial
  output logic dout_o,                       // serial data out
  output logic dout_oe_o,                    // data out driven
  output logic conversion_strobe_out_o,      // conversion strobe
  output logic strobe_oe_o,                  // strobe driven
  output logic [RES_BITS-1:0] dac_trial_o,   // trial code to the dac
  output logic [2:0] channel_o,              // selected channel
  output logic unipolar_o,                   // unipolar input range
  output logic single_ended_o,               // single-ended input
  output logic pwr_on_o,                     // analog section powered
  output logic int_clk_slow_o,               // internal clock at 225 kHz
  output logic ext_clk_mode_o                // external conversion clock
);
  typedef struct packed {
    conv_state_t st;
    logic [7:0] ctl;
    logic [3:0] nbits;
    logic ext_mode;
    logic pd_after;
    logic sw_pd;
    logic hw_pd;
    logic [RES_BITS-1:0] sar;
    logic [RES_BITS-1:0] trial;
    logic [3:0] bidx;
    logic [RES_BITS-1:0] out;
    logic [TICK_W-1:0] tick;
    logic strobe;
    logic strobe_oe;
    logic dout;
    logic dout_oe;
    logic cs_prev;
    logic [2:0] chan;
    logic uni;
    logic sgl;
    logic slow;
    logic pwr_on;
  } core_t;

  pin_evt_if ev ();

  pin_sync u_sync (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .sclk_i(sclk_i),
    .cs_n_i(cs_n_i),
    .din_i(din_i),
    .hard_shutdown_pin_n_i(hard_shutdown_pin_i),
    .hard_shutdown_pin_open_i(shutdown_pin_open_i),
    .comp_i(comp_i),
    .ev(ev.src)
  );

  core_t q;
  core_t d;
  logic [TICK_W-1:0] tick_lim;
  logic dec_ext;
  logic dec_int;
  logic fin;
  logic start_conv;
  logic [1:0] mode_bits;

  // bipolar codes leave the sar offset-binary, flip msb for two's complement
  function automatic logic [RES_BITS-1:0] out_code(input logic [RES_BITS-1:0] s,
                                                   input logic uni);
    out_code = uni ? s : {~s[RES_BITS-1], s[RES_BITS-2:0]};
  endfunction : out_code

  function automatic logic [RES_BITS-1:0] bit_mask(input logic [3:0] idx);
    bit_mask = CODE_ONE << idx;
  endfunction : bit_mask

  assign mode_bits = q.ctl[1:0];
  assign tick_lim = ev.hard_shutdown_pin_open ? TICK_W'(FAST_DIV_P - 1) : TICK_W'(SLOW_DIV_P - 1);
  assign dec_ext = q.st == ST_CONV_EXT && ev.sclk_fall && !ev.cs_n;
  // rate pin may move mid conversion; never let the tick run past the limit
  assign dec_int = q.st == ST_CONV_INT && q.tick >= tick_lim;
  assign fin = ev.hard_shutdown_pin_n && (dec_ext || dec_int) && q.bidx == 4'h0;
  assign start_conv = ev.hard_shutdown_pin_n && q.st == ST_SHIFT && ev.sclk_fall && !ev.cs_n
                      && q.nbits == CTRL_BITS;

  always_comb begin
    d = q;
    d.cs_prev = ev.cs_n;
    d.dout_oe = !ev.cs_n;
    d.slow = !ev.hard_shutdown_pin_open;
    // internal mode keeps the strobe driven with chip select high
    d.strobe_oe = !ev.cs_n || !q.ext_mode;
    if (q.ext_mode && q.cs_prev && !ev.cs_n && q.st != ST_CONV_INT) begin
      d.strobe = 1'b0;
    end
    if (!ev.hard_shutdown_pin_n) begin
      // abort without finishing; clock mode kept for the wake-up
      d.st = ST_IDLE;
      d.hw_pd = 1'b1;
      d.nbits = 4'h0;
    end else begin
      d.hw_pd = 1'b0;
      case (q.st)
        ST_IDLE: begin
          if (ev.sclk_rise && !ev.cs_n && ev.din) begin
            d.st = ST_SHIFT;
            d.ctl = CTRL_START;
            d.nbits = 4'h1;
            d.sw_pd = 1'b0;
          end else if (ev.sclk_fall && !ev.cs_n) begin
            d.dout = q.out[RES_BITS-1];
            d.out = {q.out[RES_BITS-2:0], 1'b0};
          end
        end
        ST_SHIFT: begin
          if (ev.cs_n) begin
            d.st = ST_IDLE;
          end else if (ev.sclk_rise && q.nbits != CTRL_BITS) begin
            d.ctl = {q.ctl[6:0], ev.din};
            d.nbits = q.nbits + 4'h1;
          end else if (start_conv) begin
            // unassigned code leaves the clock mode unchanged
            if (mode_bits[1]) begin
              d.ext_mode = mode_bits[0];
            end
            d.pd_after = mode_bits == MODE_PD;
            d.chan = q.ctl[CHAN_HI:CHAN_LO];
            d.uni = q.ctl[UNI_POS];
            d.sgl = q.ctl[SGL_POS];
            d.sar = CODE_ZERO;
            d.bidx = RES_MSB;
            d.tick = '0;
            d.nbits = 4'h0;
            // power-down keeps converting in the clock mode already chosen
            if (mode_bits[1] ? mode_bits[0] : q.ext_mode) begin
              d.st = ST_CONV_EXT;
              d.strobe = 1'b1;
            end else begin
              d.st = ST_CONV_INT;
              d.strobe = 1'b0;
            end
          end
        end
        ST_CONV_EXT: begin
          if (ev.cs_n) begin
            d.st = ST_IDLE;
          end else if (dec_ext) begin
            d.strobe = 1'b0;
            d.sar = q.sar | (ev.comp ? bit_mask(q.bidx) : CODE_ZERO);
            // bipolar msb leaves inverted so the stream is two's complement
            d.dout = ev.comp ^ (q.bidx == RES_MSB && !q.uni);
            d.bidx = q.bidx - 4'h1;
          end
        end
        ST_CONV_INT: begin
          // chip select high does not disturb an internal conversion
          if (dec_int) begin
            d.tick = '0;
            d.sar = q.sar | (ev.comp ? bit_mask(q.bidx) : CODE_ZERO);
            d.bidx = q.bidx - 4'h1;
          end else begin
            d.tick = q.tick + TICK_W'(1);
          end
        end
        default: begin
          d.st = ST_IDLE;
        end
      endcase
      if (fin) begin
        d.st = ST_IDLE;
        d.sw_pd = q.pd_after;
        if (q.st == ST_CONV_INT) begin
          d.out = out_code(d.sar, q.uni);
          d.strobe = 1'b1;
        end else begin
          // trailing bits in external mode read as zero
          d.out = CODE_ZERO;
        end
      end
    end
    // trial lies half a step above the bit boundary via the dac offset
    d.trial = d.sar | bit_mask(d.bidx);
    d.pwr_on = !d.sw_pd && !d.hw_pd;
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      q <= '{st: ST_IDLE, ctl: 8'h00, nbits: 4'h0, ext_mode: 1'b0, pd_after: 1'b0,
             sw_pd: 1'b0, hw_pd: 1'b0, sar: CODE_ZERO, trial: CODE_ZERO, bidx: RES_MSB,
             out: CODE_ZERO, tick: '0, strobe: 1'b1, strobe_oe: 1'b1, dout: 1'b0,
             dout_oe: 1'b0, cs_prev: 1'b1, chan: 3'h0, uni: 1'b0, sgl: 1'b0,
             slow: 1'b0, pwr_on: 1'b1};
    end else begin
      q <= d;
    end
  end

  assign dout_o = q.dout;
  assign dout_oe_o = q.dout_oe;
  assign conversion_strobe_out_o = q.strobe;
  assign strobe_oe_o = q.strobe_oe;
  assign dac_trial_o = q.trial;
  assign channel_o = q.chan;
  assign unipolar_o = q.uni;
  assign single_ended_o = q.sgl;
  assign pwr_on_o = q.pwr_on;
  assign int_clk_slow_o = q.slow;
  assign ext_clk_mode_o = q.ext_mode;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  sequence int_run_s;
    q.st == ST_CONV_INT && ev.hard_shutdown_pin_n;
  endsequence
  sequence int_done_s;
    int_run_s ##0 fin;
  endsequence

  mode_ext_decode_a: assert property (start_conv && mode_bits == MODE_EXT |=> ext_clk_mode_o && q.st == ST_CONV_EXT) else $error("external mode not taken");
  mode_int_decode_a: assert property (start_conv && mode_bits == MODE_INT |=> !ext_clk_mode_o ##0 !conversion_strobe_out_o) else $error("internal mode not taken");
  hard_shutdown_pin_rate_a: assert property (ev.hard_shutdown_pin_n && !ev.hard_shutdown_pin_open |=> int_clk_slow_o) else $error("slow rate not chosen");
  pd_wait_conv_a: assert property (q.st == ST_CONV_EXT |-> !q.sw_pd) else $error("powered down mid conversion");
  pd_shift_out_a: assert property (q.st == ST_IDLE && q.sw_pd && ev.hard_shutdown_pin_n && ev.sclk_fall && !ev.cs_n && !(ev.sclk_rise) |=> dout_o == $past(q.out[RES_BITS-1])) else $error("result not shifted");
  start_wake_a: assert property (q.st == ST_IDLE && ev.hard_shutdown_pin_n && ev.sclk_rise && !ev.cs_n && ev.din |=> q.st == ST_SHIFT && pwr_on_o) else $error("start bit missed");
  single_conv_pd_a: assert property (fin && q.pd_after |=> !pwr_on_o && q.st == ST_IDLE) else $error("no power-down after conversion");
  hard_shutdown_pin_abort_a: assert property (!ev.hard_shutdown_pin_n |=> q.st == ST_IDLE && !pwr_on_o) else $error("shutdown did not abort");
  conv_start_a: assert property (start_conv |=> q.st == ST_CONV_EXT || q.st == ST_CONV_INT) else $error("conversion not started");
  strobe_pulse_a: assert property (q.st == ST_CONV_EXT && q.strobe && dec_ext |=> !conversion_strobe_out_o ##0 q.bidx == 4'ha) else $error("strobe pulse wrong");
  int_strobe_done_a: assert property (int_done_s |=> conversion_strobe_out_o ##0 q.out == out_code($past(d.sar), q.uni)) else $error("strobe not raised");
endmodule : adc_power_clock_mode_ctrl

// File: dv/host_master.sv
// host serial master model driving the converter link
`timescale 1ns/100ps
module host_master (
  input wire logic clock_i,  // bench clock, paces the link
  input wire logic dout_i,   // serial data from device
  input wire logic strobe_i, // strobe from device
  output logic sclk_o,       // serial clock, idle low
  output logic cs_n_o,       // chip select, low active
  output logic din_o         // serial data to device
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end
  // half of the 160 ns link period in bench cycles
  // link rate scaled down with the shortened internal dividers
  task automatic half;
    repeat (16) @(negedge clock_i);
  endtask : half
  task automatic sel(input logic on);
    @(negedge clock_i);
    cs_n_o = !on;
    // a released line must not keep showing its last value
    if (!on) begin
      din_o = !din_o;
    end
    half();
  endtask : sel
  // data set while the clock is low, taken on the rise
  task automatic xfer8(input logic [7:0] tx, output logic [7:0] rx, output logic [7:0] sb);
    for (int i = 7; i >= 0; i--) begin
      din_o = tx[i];
      half();
      sclk_o = 1'b1;
      rx[i] = dout_i;
      sb[i] = strobe_i;
      half();
      sclk_o = 1'b0;
    end
  endtask : xfer8
endmodule : host_master

// File: dv/adc_power_clock_mode_ctrl_tb.sv
// self-checking bench for the converter control block
`timescale 1ns/100ps
module adc_power_clock_mode_ctrl_tb;
  import adc_ctrl_pkg::*;
  localparam int FDIV = 4;
  localparam int SDIV = 8;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic hard_shutdown_pin_n = 1'b1;
  logic hard_shutdown_pin_open = 1'b1;
  logic comp = 1'b0;
  logic sclk, cs_n, din, dout, dout_oe, strobe, strobe_oe, uni, sgl, pwr_on, slow, ext;
  logic [RES_BITS-1:0] trial;
  logic [2:0] chan;
  logic [11:0] target = 12'h0000;
  int error_cnt = 0;
  int cmp_count = 0;
  initial begin
    forever #2.5 clock_i = !clock_i;
  end
  adc_power_clock_mode_ctrl #(.FAST_DIV_P(FDIV), .SLOW_DIV_P(SDIV)) dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .hard_shutdown_pin_i(hard_shutdown_pin_n), .shutdown_pin_open_i(hard_shutdown_pin_open), .comp_i(comp),
    .dout_o(dout), .dout_oe_o(dout_oe), .conversion_strobe_out_o(strobe),
    .strobe_oe_o(strobe_oe), .dac_trial_o(trial), .channel_o(chan), .unipolar_o(uni),
    .single_ended_o(sgl), .pwr_on_o(pwr_on), .int_clk_slow_o(slow), .ext_clk_mode_o(ext));
  host_master host (.clock_i(clock_i), .dout_i(dout), .strobe_i(strobe), .sclk_o(sclk),
    .cs_n_o(cs_n), .din_o(din));
  // analog level sits half a step above the target code
  always @(negedge clock_i) begin
    comp <= (trial <= target);
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  function automatic logic [11:0] exp_code(input logic [11:0] t, input logic u);
    return u ? t : (t ^ 12'h0800);
  endfunction : exp_code
  task automatic convert(input logic [1:0] mode);
    logic [7:0] rx1, rx2, rx3, sb1, sb2, sb3;
    logic [2:0] ch;
    logic u, s;
    int n, lim;
    ch = 3'($urandom());
    u = 1'($urandom());
    s = 1'($urandom());
    host.sel(1'b1);
    host.xfer8({1'b1, ch, u, s, mode}, rx1, sb1);
    repeat (6) @(negedge clock_i);
    check("fields", {11'h0, chan, uni, sgl}, {11'h0, ch, u, s});
    check("ext flag", 16'(ext), 16'(mode == MODE_EXT));
    check("strobe", 16'(strobe), 16'(mode == MODE_EXT));
    check("power up", 16'(pwr_on), 16'h0001);
    check("data oe", 16'(dout_oe), 16'h0001);
    if (mode != MODE_EXT) begin
      check("slow flag", 16'(slow), 16'(!hard_shutdown_pin_open));
      lim = 12 * (hard_shutdown_pin_open ? FDIV : SDIV);
      n = 0;
      while (strobe !== 1'b1 && n < 12 * SDIV + 40) begin
        @(negedge clock_i);
        n++;
      end
      check("conv time", 16'(n >= lim - 10 && n <= lim + 10), 16'h0001);
      repeat (4) @(negedge clock_i);
      check("power after", 16'(pwr_on), 16'(mode[1]));
    end
    host.xfer8(8'h00, rx2, sb2);
    host.xfer8(8'h00, rx3, sb3);
    check("result", {1'b0, rx2[6:0], rx3}, {1'b0, exp_code(target, u), 3'h0});
    if (mode == MODE_EXT) begin
      check("strobe pulse", {14'h0, sb2[7:6]}, 16'h0002);
    end
    host.sel(1'b0);
    check("data oe off", 16'(dout_oe), 16'h0000);
    check("strobe oe", 16'(strobe_oe), 16'(mode != MODE_EXT));
  endtask : convert
  // shutdown pin pulled low in mid-conversion, then a byte while it stays low
  task automatic hard_off;
    logic [7:0] rx, sb;
    hard_shutdown_pin_open = 1'b0;
    host.sel(1'b1);
    host.xfer8({1'b1, 3'h5, 2'h3, MODE_INT}, rx, sb);
    repeat (20) @(negedge clock_i);
    hard_shutdown_pin_n = 1'b0;
    repeat (8) @(negedge clock_i);
    check("hw off", 16'(pwr_on), 16'h0000);
    host.xfer8({1'b1, 3'h2, 2'h3, MODE_EXT}, rx, sb);
    repeat (8) @(negedge clock_i);
    check("hw override", 16'(pwr_on), 16'h0000);
    host.sel(1'b0);
    hard_shutdown_pin_n = 1'b1;
    repeat (8) @(negedge clock_i);
    check("hw back", 16'(pwr_on), 16'h0001);
    check("hw mode kept", 16'(ext), 16'h0000);
  endtask : hard_off
  initial begin
    int k;
    void'($urandom(32'h4e16));
    repeat (2) @(negedge clock_i);
    sys_rst_i = 1'b0;
    repeat (6) @(negedge clock_i);
    check("reset", {14'h0, strobe, pwr_on}, 16'h0003);
    for (int i = 0; i < 14; i++) begin
      k = (i < 3) ? i : int'($urandom_range(2));
      target = (i == 0) ? 12'h0fff : (i == 1) ? 12'h0000 : (i == 2) ? 12'h07ff : 12'($urandom());
      hard_shutdown_pin_open = 1'($urandom());
      convert(k == 0 ? MODE_EXT : MODE_INT);
      if (k == 2) begin
        convert(MODE_PD);
      end
      if (i == 5) begin
        hard_off();
      end
    end
    tally_and_finish();
  end
  // about five times the expected run length
  initial begin
    #400us;
    error_cnt++;
    tally_and_finish();
  end
endmodule : adc_power_clock_mode_ctrl_tb
